/* stepper_pkg.sv */
// Constants for the stepper energy pulse drive.
// Assumes a single 100 MHz clock domain.
package stepper_pkg;
  localparam int CLK_HZ = 100_000_000;
  // Mono-flop widths in microseconds
  localparam int MONO_SHORT_US = 31250;
  localparam int MONO_LONG_US = 156250;
  localparam int MONO_SHORT_CYC = MONO_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int MONO_LONG_CYC = MONO_LONG_US * (CLK_HZ / 1_000_000);
  localparam int ENERGY_W = 20;
  localparam int POWER_W = 20;
  localparam int DIV_W = 12;
  // Motor divide ratios, codes 0..3, long-pulse multiplier
  localparam logic [11:0] DIV_K0 = 12'h040;
  localparam logic [11:0] DIV_K1 = 12'h080;
  localparam logic [11:0] DIV_K2 = 12'h020;
  localparam logic [11:0] DIV_K3 = 12'h100;
  localparam logic [11:0] LONG_MULT = 12'h00A;
  localparam logic [1:0] ACC_SIGNED_GATE = 2'h0;
  localparam logic [1:0] ACC_ABS = 2'h1;
  localparam logic [1:0] ACC_FERRARIS = 2'h2;
  localparam logic [1:0] ACC_SIGNED_RUN = 2'h3;
  localparam logic [1:0] APL_STANDALONE_FULL = 2'h2;
  localparam logic [1:0] APL_STANDALONE_DIV = 2'h3;

  // Divide ratio for a code and long-pulse select
  function automatic logic [11:0] div_ratio(input logic [1:0] code, input logic long_sel);
    logic [11:0] base;
    base = DIV_K0;
    case (code)
      2'h0: base = DIV_K0;
      2'h1: base = DIV_K1;
      2'h2: base = DIV_K2;
      default: base = DIV_K3;
    endcase
    div_ratio = long_sel ? 12'(base * LONG_MULT) : base;
  endfunction : div_ratio
endpackage : stepper_pkg

/* pulse_divider.sv */
// Divides an input pulse stream by a run-time ratio.
// Assumes one-cycle input pulses synchronous to clk.
`timescale 1ns/1ps
module pulse_divider import stepper_pkg::*; #(
  parameter int W = DIV_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic pulse_in,
  input wire logic [W-1:0] ratio,
  output logic pulse_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } div_s;
  div_s st_reg, st_next;

  // Count input pulses, emit one per ratio
  always_comb begin
    st_next = st_reg;
    st_next.out = 1'b0;
    if (clr) begin
      st_next.cnt = '0;
    end else if (pulse_in) begin
      if (st_reg.cnt >= ratio - W'(1)) begin
        st_next.cnt = '0;
        st_next.out = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_out = st_reg.out;
endmodule : pulse_divider

/* stepper_energy_pulse_drive.sv */
// Energy accumulation, LED pulse and stepper drive in standalone mode.
// Assumes phase powers and a power strobe synchronous to clk.
`timescale 1ns/1ps
module stepper_energy_pulse_drive import stepper_pkg::*; #(
  parameter int MONO_SHORT = MONO_SHORT_CYC,
  parameter int MONO_LONG = MONO_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_strobe,
  input wire logic signed [POWER_W-1:0] power_r,
  input wire logic signed [POWER_W-1:0] power_s,
  input wire logic signed [POWER_W-1:0] power_t,
  input wire logic signed [POWER_W-1:0] power_fund,
  input wire logic signed [POWER_W-1:0] power_reactive,
  input wire logic signed [POWER_W-1:0] power_reactive_fund,
  input wire logic [1:0] application_mode_sel,
  input wire logic long_pulse_reactive_sel,
  input wire logic fund_sel,
  input wire logic [1:0] motor_divider_code,
  input wire logic [1:0] neg_power_accum_mode,
  input wire logic no_load_flag,
  input wire logic alt_pos_func,
  input wire logic alt_neg_func,
  output logic motor_out_pos_pin,
  output logic motor_out_neg_pin,
  output logic led_pin,
  output logic sign_total,
  output logic [2:0] sign_phase
);
  typedef struct packed {
    logic [ENERGY_W-1:0] acc_p;
    logic [ENERGY_W-1:0] acc_f;
    logic [ENERGY_W-1:0] acc_q;
    logic [ENERGY_W-1:0] acc_r;
    logic p_pulse;
    logic led_src;
    logic [31:0] mono_cnt;
    logic side_b;
    logic drive_a;
    logic drive_b;
    logic led;
    logic sgn;
    logic [2:0] sgn_ph;
  } drive_s;
  drive_s st_reg, st_next;

  logic standalone;
  logic motor_pulse;
  logic led_div_pulse;
  logic [DIV_W-1:0] motor_ratio;
  logic [DIV_W-1:0] led_ratio;
  logic signed [POWER_W+1:0] sum_signed;
  logic [POWER_W+1:0] sum_abs;
  logic [POWER_W+1:0] sum_ferr;
  logic [POWER_W+1:0] p_add;
  logic p_neg;

  function automatic logic [POWER_W+1:0] mag(input logic signed [POWER_W-1:0] v);
    mag = v[POWER_W-1] ? (POWER_W+2)'(-v) : (POWER_W+2)'(v);
  endfunction : mag

  function automatic logic [POWER_W+1:0] pos(input logic signed [POWER_W-1:0] v);
    pos = v[POWER_W-1] ? '0 : (POWER_W+2)'(v);
  endfunction : pos

  assign standalone = application_mode_sel[1];

  // Power combination per accumulation mode
  always_comb begin
    sum_signed = (POWER_W+2)'(power_r) + (POWER_W+2)'(power_s) + (POWER_W+2)'(power_t);
    sum_abs = mag(power_r) + mag(power_s) + mag(power_t);
    sum_ferr = pos(power_r) + pos(power_s) + pos(power_t);
    p_neg = sum_signed[POWER_W+1];
    case (neg_power_accum_mode)
      ACC_ABS: p_add = sum_abs;
      ACC_FERRARIS: p_add = sum_ferr;
      default: p_add = p_neg ? (POWER_W+2)'(-sum_signed) : (POWER_W+2)'(sum_signed);
    endcase
  end

  assign motor_ratio = div_ratio(motor_divider_code, long_pulse_reactive_sel);
  assign led_ratio = div_ratio(motor_divider_code, 1'b0);

  // Energy pulse divided to motor rate
  pulse_divider #(.W(DIV_W)) u_motor_div (
    .clk(clk),
    .rst(rst),
    .clr(no_load_flag),
    .pulse_in(st_reg.p_pulse),
    .ratio(motor_ratio),
    .pulse_out(motor_pulse)
  );

  // Energy pulse divided to LED rate in mode 3
  pulse_divider #(.W(DIV_W)) u_led_div (
    .clk(clk),
    .rst(rst),
    .clr(no_load_flag),
    .pulse_in(st_reg.p_pulse),
    .ratio(led_ratio),
    .pulse_out(led_div_pulse)
  );

  // Accumulators, mono-flop, decoder, LED and sign status
  always_comb begin
    logic [ENERGY_W:0] sp;
    logic [ENERGY_W:0] sf;
    logic [ENERGY_W:0] sq;
    logic [ENERGY_W:0] sr;
    logic blank;
    logic [ENERGY_W-1:0] f_add;
    sp = '0;
    sf = '0;
    sq = '0;
    sr = '0;
    f_add = '0;
    blank = 1'b0;
    st_next = st_reg;
    st_next.p_pulse = 1'b0;
    st_next.led_src = 1'b0;
    st_next.led = 1'b0;
    if (power_strobe && !no_load_flag) begin
      // Accumulation mode applies to active energies only
      if (neg_power_accum_mode == ACC_ABS || neg_power_accum_mode == ACC_FERRARIS) begin
        f_add = ENERGY_W'(mag(power_fund));
      end else begin
        f_add = ENERGY_W'(pos(power_fund));
      end
      sp = {1'b0, st_reg.acc_p} + (ENERGY_W+1)'(p_add);
      sf = {1'b0, st_reg.acc_f} + {1'b0, f_add};
      sq = {1'b0, st_reg.acc_q} + (ENERGY_W+1)'(mag(power_reactive));
      sr = {1'b0, st_reg.acc_r} + (ENERGY_W+1)'(mag(power_reactive_fund));
      st_next.acc_p = sp[ENERGY_W-1:0];
      st_next.acc_f = sf[ENERGY_W-1:0];
      st_next.acc_q = sq[ENERGY_W-1:0];
      st_next.acc_r = sr[ENERGY_W-1:0];
      st_next.p_pulse = sp[ENERGY_W];
      case ({long_pulse_reactive_sel, fund_sel})
        2'h0: st_next.led_src = sp[ENERGY_W];
        2'h1: st_next.led_src = sf[ENERGY_W];
        2'h2: st_next.led_src = sq[ENERGY_W];
        default: st_next.led_src = sr[ENERGY_W];
      endcase
      st_next.sgn = (neg_power_accum_mode == ACC_SIGNED_GATE ||
                     neg_power_accum_mode == ACC_SIGNED_RUN) ? !p_neg : 1'b1;
      st_next.sgn_ph = {!power_t[POWER_W-1], !power_s[POWER_W-1], !power_r[POWER_W-1]};
    end
    // LED source per application mode
    case (application_mode_sel)
      APL_STANDALONE_FULL: st_next.led = st_reg.p_pulse;
      APL_STANDALONE_DIV: st_next.led = led_div_pulse;
      default: st_next.led = st_reg.led_src;
    endcase
    // Mode 0 blanks the motor while total is negative
    blank = no_load_flag || !standalone ||
            (neg_power_accum_mode == ACC_SIGNED_GATE && !st_reg.sgn);
    if (st_reg.mono_cnt != 0) begin
      st_next.mono_cnt = st_reg.mono_cnt - 32'(1);
      if (st_reg.mono_cnt == 32'(1)) begin
        st_next.drive_a = 1'b0;
        st_next.drive_b = 1'b0;
      end
    end else if (motor_pulse && !blank) begin
      st_next.mono_cnt = long_pulse_reactive_sel ? 32'(MONO_LONG) : 32'(MONO_SHORT);
      st_next.drive_a = !st_reg.side_b;
      st_next.drive_b = st_reg.side_b;
      st_next.side_b = !st_reg.side_b;
    end
    if (blank) begin
      st_next.drive_a = 1'b0;
      st_next.drive_b = 1'b0;
      st_next.mono_cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Motor pins fall back to other functions outside standalone
  assign motor_out_pos_pin = standalone ? st_reg.drive_a : alt_pos_func;
  assign motor_out_neg_pin = standalone ? st_reg.drive_b : alt_neg_func;
  assign led_pin = st_reg.led;
  assign sign_total = st_reg.sgn;
  assign sign_phase = st_reg.sgn_ph;

  exclusive_drive_a: assert property (@(posedge clk) disable iff (rst)
    !(st_reg.drive_a && st_reg.drive_b)) else $error("both drives high");
  no_load_low_a: assert property (@(posedge clk) disable iff (rst)
    no_load_flag |=> !st_reg.drive_a && !st_reg.drive_b) else $error("drive under no-load");
  standalone_pin_a: assert property (@(posedge clk) disable iff (rst)
    application_mode_sel[1] |-> motor_out_pos_pin == st_reg.drive_a) else $error("pin mux");
  alt_pin_a: assert property (@(posedge clk) disable iff (rst)
    !application_mode_sel[1] |-> motor_out_neg_pin == alt_neg_func) else $error("alt mux");
  alternate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.drive_a) |-> st_reg.side_b && !$past(st_reg.side_b))
    else $error("decoder order");
  neg_blank_a: assert property (@(posedge clk) disable iff (rst)
    (neg_power_accum_mode == ACC_SIGNED_GATE && !st_reg.sgn) |=> !st_reg.drive_a)
    else $error("negative drive");
  abs_sign_a: assert property (@(posedge clk) disable iff (rst)
    (power_strobe && !no_load_flag && neg_power_accum_mode == ACC_ABS) |=> sign_total)
    else $error("abs sign");
  mono_load_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.drive_a || st_reg.drive_b) |-> st_reg.mono_cnt ==
    ($past(long_pulse_reactive_sel) ? 32'(MONO_LONG) : 32'(MONO_SHORT)))
    else $error("mono width");
  ferr_sign_a: assert property (@(posedge clk) disable iff (rst)
    (power_strobe && !no_load_flag && neg_power_accum_mode == ACC_FERRARIS) |=> sign_total)
    else $error("ferraris sign");
  led_full_a: assert property (@(posedge clk) disable iff (rst)
    (application_mode_sel == APL_STANDALONE_FULL && st_reg.p_pulse) |=> led_pin)
    else $error("led full rate");

  drive_a_c: cover property (@(posedge clk) disable iff (rst) $rose(st_reg.drive_a));
  drive_b_c: cover property (@(posedge clk) disable iff (rst) $rose(st_reg.drive_b));
  led_c: cover property (@(posedge clk) disable iff (rst) led_pin);
  neg_c: cover property (@(posedge clk) disable iff (rst) !sign_total);
endmodule : stepper_energy_pulse_drive

/* stepper_motor_model.sv */
// Behavioural stepper motor with two coils and an energy indicator LED.
// Assumes coil and LED levels are registered outputs on the rising edge of clk.
`timescale 1ns/1ps
module stepper_motor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic coil_a,
  input wire logic coil_b,
  input wire logic led,
  output int led_count,
  output int position
);
  logic prev_a;
  logic prev_b;
  logic last_b;

  // Rotor advances only when the other coil fires; a repeat coil stalls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      led_count <= 0;
      position <= 0;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      last_b <= 1'b1;
    end else begin
      if (led) led_count <= led_count + 1;
      if (coil_a && !prev_a && last_b) position <= position + 1;
      if (coil_b && !prev_b && !last_b) position <= position + 1;
      if (coil_a && !prev_a) last_b <= 1'b0;
      if (coil_b && !prev_b) last_b <= 1'b1;
      prev_a <= coil_a;
      prev_b <= coil_b;
    end
  end
endmodule : stepper_motor_model

/* test_stepper_energy_pulse_drive.sv */
// Self-checking bench for the stepper energy pulse drive.
// Assumes short mono-flop counts in simulation and one 100 MHz clock.
`timescale 1ns/1ps
module test_stepper_energy_pulse_drive import stepper_pkg::*;;
  localparam int MS = 20;
  localparam int ML = 50;
  logic clk = 0, rst = 1, strobe = 0, long_sel = 0, fund_sel = 0, no_load = 0;
  logic alt_p = 0, alt_n = 0, watch = 0, pa = 0, pb = 0;
  logic signed [POWER_W-1:0] pr = '0;
  logic signed [POWER_W-1:0] pq = '0;
  logic [1:0] amode = 2'h2, code = 2'h0, acc = 2'h0;
  logic mp, mn, led, st;
  logic [2:0] sp;
  int mismatches = 0, num_checks = 0, seed = 5, cyc = 0, wid = 0, led_count, position, r;
  int base[4] = '{64, 128, 32, 256};
  logic q[$];

  stepper_energy_pulse_drive #(.MONO_SHORT(MS), .MONO_LONG(ML)) u_dut (.clk(clk), .rst(rst),
    .power_strobe(strobe), .power_r(pr), .power_s('0), .power_t('0), .power_fund('0),
    .power_reactive(pq), .power_reactive_fund('0), .application_mode_sel(amode),
    .long_pulse_reactive_sel(long_sel), .fund_sel(fund_sel), .motor_divider_code(code),
    .neg_power_accum_mode(acc), .no_load_flag(no_load), .alt_pos_func(alt_p),
    .alt_neg_func(alt_n), .motor_out_pos_pin(mp), .motor_out_neg_pin(mn), .led_pin(led),
    .sign_total(st), .sign_phase(sp));
  stepper_motor_model u_motor (.clk(clk), .rst(rst), .coil_a(mp), .coil_b(mn), .led(led),
    .led_count(led_count), .position(position));

  // Clock and hang guard
  initial forever #5 clk = ~clk;
  initial forever begin
    @(posedge clk);
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Watches each drive pulse against the oldest queued note
  always @(negedge clk) begin
    if (watch) begin
      if ((mp && !pa) || (mn && !pb)) begin
        if (q.size() == 0) chk("unexpected_motor_pulse", 0, 1);
        else chk("motor_pin", q.pop_front(), mn);
      end
      if (mp && mn) chk("both_drives_high", 0, 1);
      if (mp || mn) wid++;
      else if (wid != 0) begin
        chk("pulse_width", (long_sel ? ML : MS), wid);
        wid = 0;
      end
      pa = mp;
      pb = mn;
    end else begin
      pa = 0;
      pb = 0;
      wid = 0;
    end
  end

  // One standalone run: e energy pulses, then drain and compare
  task automatic run(input logic [1:0] am, input logic ls, input logic [1:0] cd,
                     input logic [1:0] ac, input logic signed [19:0] p, input logic nl,
                     input int e, input int exp_led, input int pulses, input logic es);
    rst = 1;
    repeat (8) @(posedge clk);
    #1;
    amode = am;
    long_sel = ls;
    code = cd;
    acc = ac;
    pr = p;
    no_load = nl;
    fund_sel = 1'($random(seed));
    rst = 0;
    watch = 1;
    for (int i = 0; i < pulses; i++) q.push_back(i[0]);
    strobe = 1;
    repeat (4 * e) @(posedge clk);
    #1 strobe = 0;
    repeat (150) @(posedge clk);
    chk("led_count", exp_led, led_count);
    chk("queued_pulses_left", 0, q.size());
    chk("motor_position", pulses, position);
    chk("sign_total", es, st);
    chk("sign_phase", nl ? 3'h0 : {2'b11, p >= 0}, sp);
    watch = 0;
    q.delete();
    $display("test mode %0d long %0d code %0d acc %0d done", am, ls, cd, ac);
  endtask : run

  initial begin
    for (int ls = 0; ls < 2; ls++) begin
      for (int c = 0; c < 4; c++) begin
        r = base[c] * (ls ? 10 : 1);
        run(c[0] ? 2'h3 : 2'h2, ls[0], c[1:0], 2'h0, 20'sh40000, 0, 2 * r,
            c[0] ? 2 * (ls ? 10 : 1) : 2 * r, 2, 1);
      end
    end
    for (int m = 0; m < 4; m++) begin
      run(2'h2, 0, 2'h2, m[1:0], m == 2 ? 20'sh40000 : -20'sh40000, 0, 64, 64,
          m == 0 ? 0 : 2, m == 1 || m == 2);
    end
    run(2'h2, 0, 2'h2, 2'h0, 20'sh40000, 1, 64, 0, 0, 0);
    // Non-standalone: pins follow alternate functions, LED shows reactive energy
    @(posedge clk);
    #1 amode = {1'b0, 1'($random(seed))};
    no_load = 0;
    long_sel = 1;
    fund_sel = 0;
    pq = 20'sh40000;
    r = led_count;
    strobe = 1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1 alt_p = 1'($random(seed));
      alt_n = 1'($random(seed));
      @(negedge clk);
      chk("alt_pos", alt_p, mp);
      chk("alt_neg", alt_n, mn);
    end
    @(posedge clk);
    #1 strobe = 0;
    repeat (3) @(posedge clk);
    #1 chk("led_reactive", r + 75, led_count);
    $display("test alternate pin functions done");
    conclude();
  end
endmodule : test_stepper_energy_pulse_drive
